// File: design/dacc_top.sv
// apb register slave and digital control of the 5-bit ladder converter
//
// What this block does
// - control bit 7 enables the converter
// - level bits 4:0 pick one of 32
// - bits 5 and 4 connect pins 1, 2
// - at most one output pin driven
// - driven pin: buffers off, reads zero
// - bits 3:2 select the positive source
// - bit 0 selects the negative source
// - sleep and wake keep control contents
// - reset clears enable, pins, level code
// - control at 0x90E, level at 0x90F
//
// Implementation choice: the APB slave port.
`include "dacc_regs.svh"

module dacc_top
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [13:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // power state, informational only
  input  wire logic              sleep_mode,
  // analog ladder controls
  output dacc_pkg::dacc_ladder_t ladder,
  // pad overrides for the two output pins
  output dacc_pkg::dacc_pins_t   pin_analog,
  output dacc_pkg::dacc_pins_t   pin_digital_off,
  output dacc_pkg::dacc_pins_t   pin_pullup_off,
  output dacc_pkg::dacc_pins_t   pin_ccd_off,
  // pad read values: raw from the pins in, synchronised and forced to zero on an analog pin out
  input  wire logic              pad_in_pin1,
  input  wire logic              pad_in_pin2,
  output logic                   pin1_read,
  output logic                   pin2_read
);
  import dacc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  logic [7:0] ctrl_r;
  logic [4:0] level_r;
  logic       sel_ctrl;
  logic       sel_level;
  logic       wr_en;
  logic       p1_s1_r;
  logic       p1_s2_r;
  logic       p2_s1_r;
  logic       p2_s2_r;
  logic       drive1;
  logic       drive2;

  // registers answer with zero wait states
  assign pready    = 1'b1;
  assign sel_ctrl  = (paddr == `DACC_CTRL_ADDR);
  assign sel_level = (paddr == `DACC_LEVEL_ADDR);
  // unmapped addresses answer with an error and have no effect
  assign pslverr   = psel & penable & ~(sel_ctrl | sel_level);
  // only the low byte lane carries register data
  assign wr_en     = psel & penable & pwrite & pstrb[0];

  ////////////////////////////////////////////////////////////////////////////////
  // control register; sleep_mode is deliberately not used so state survives wake

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_r <= `DACC_CTRL_RST;
    else if (wr_en && sel_ctrl)
    begin
      ctrl_r <= pwdata[7:0] & `DACC_CTRL_MASK;
      // both pins requested: keep pin 1 only, so the pair stays one-hot
      if (pwdata[`DACC_OE1_BIT] && pwdata[`DACC_OE2_BIT])
        ctrl_r[`DACC_OE2_BIT] <= 1'b0;
    end
  end

  // level register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      level_r <= `DACC_LEVEL_RST;
    else if (wr_en && sel_level)
      level_r <= pwdata[4:0];
  end

  // read data registered from the setup phase so it is valid in access
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      if (sel_ctrl)
        prdata <= {24'h000000, ctrl_r};
      else if (sel_level)
        prdata <= {27'h0000000, level_r};
      else
        prdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ladder decode

  always_comb
  begin
    ladder               = '0;
    ladder.enable        = ctrl_r[`DACC_EN_BIT];
    ladder.pos_supply    = ctrl_r[`DACC_PSS_HI:`DACC_PSS_LO] == DACC_POS_SUPPLY;
    ladder.pos_ext_ref   = ctrl_r[`DACC_PSS_HI:`DACC_PSS_LO] == DACC_POS_EXT_REF;
    ladder.pos_fixed_ref = ctrl_r[`DACC_PSS_HI:`DACC_PSS_LO] == DACC_POS_FIXED;
    ladder.neg_ext_ref   = ctrl_r[`DACC_NSS_BIT];
    ladder.neg_ground    = ~ctrl_r[`DACC_NSS_BIT];
    ladder.level_code    = level_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin overrides; a pin carries the voltage whenever its enable bit is set

  assign drive1 = ctrl_r[`DACC_OE1_BIT];
  assign drive2 = ctrl_r[`DACC_OE2_BIT] & ~drive1;

  always_comb
  begin
    pin_analog.converter_out_pin1      = drive1;
    pin_analog.converter_out_pin2      = drive2;
    pin_digital_off.converter_out_pin1 = drive1;
    pin_digital_off.converter_out_pin2 = drive2;
    pin_pullup_off.converter_out_pin1  = drive1;
    pin_pullup_off.converter_out_pin2  = drive2;
    pin_ccd_off.converter_out_pin1     = drive1;
    pin_ccd_off.converter_out_pin2     = drive2;
  end

  // pad inputs pass two flops before use
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      p1_s1_r <= 1'b0;
      p1_s2_r <= 1'b0;
      p2_s1_r <= 1'b0;
      p2_s2_r <= 1'b0;
    end
    else
    begin
      p1_s1_r <= pad_in_pin1;
      p1_s2_r <= p1_s1_r;
      p2_s1_r <= pad_in_pin2;
      p2_s2_r <= p2_s1_r;
    end
  end

  // an analog pin reads zero from the cycle after its override is set
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin1_read <= 1'b0;
      pin2_read <= 1'b0;
    end
    else
    begin
      pin1_read <= p1_s2_r & ~drive1;
      pin2_read <= p2_s2_r & ~drive2;
    end
  end

endmodule // dacc_top

// File: design/dacc_regs.svh
// register offsets, field positions and reset values of the converter control block
`ifndef DACC_REGS_SVH
`define DACC_REGS_SVH

// register indices as printed; byte address is four times the index
`define DACC_CTRL_IDX      12'h90E
`define DACC_LEVEL_IDX     12'h90F
`define DACC_CTRL_ADDR     14'h2438
`define DACC_LEVEL_ADDR    14'h243C
// control field positions
`define DACC_EN_BIT        7
`define DACC_OE1_BIT       5
`define DACC_OE2_BIT       4
`define DACC_PSS_HI        3
`define DACC_PSS_LO        2
`define DACC_NSS_BIT       0
// writable bit masks
`define DACC_CTRL_MASK     8'hBD
`define DACC_LEVEL_MASK    8'h1F
// reset values
`define DACC_CTRL_RST      8'h00
`define DACC_LEVEL_RST     5'h00

`endif

// File: design/dacc_pkg.sv
// types shared by the converter control block
package dacc_pkg;

  // positive source encodings
  typedef enum logic [1:0] {
    DACC_POS_SUPPLY  = 2'h0,
    DACC_POS_EXT_REF = 2'h1,
    DACC_POS_FIXED   = 2'h2,
    DACC_POS_RSVD    = 2'h3
  } dacc_pos_t;

  // decoded analog settings handed to the ladder
  typedef struct packed {
    logic      enable;
    logic      pos_supply;
    logic      pos_ext_ref;
    logic      pos_fixed_ref;
    logic      neg_ext_ref;
    logic      neg_ground;
    logic [4:0] level_code;
  } dacc_ladder_t;

  // per-pin override controls
  typedef struct packed {
    logic converter_out_pin1;
    logic converter_out_pin2;
  } dacc_pins_t;

endpackage : dacc_pkg

// File: verif/dacc_properties.sv
// port assertions for the converter control block
module dacc_properties
(
  // clock, reset and bus
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [13:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic                   pslverr,
  // ladder and pins
  input wire dacc_pkg::dacc_ladder_t ladder,
  input wire dacc_pkg::dacc_pins_t   pin_analog,
  input wire logic                   pin1_read
);
  import dacc_pkg::*;
  // accepted writes; pstrb[0] gates them since only the low byte holds bits
  wire wr = psel && penable && pwrite && pstrb[0];
  wire wc = wr && paddr == 14'h2438;
  wire wl = wr && paddr == 14'h243C;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_en; wc |=> ladder.enable == $past(pwdata[7]); endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_lvl; wl |=> ladder.level_code == $past(pwdata[4:0]); endproperty
  a_lvl: assert property (p_lvl) else $error("level wrong");
  property p_pin; wc |=> pin_analog.converter_out_pin1 == $past(pwdata[5]); endproperty
  a_pin: assert property (p_pin) else $error("pin wrong");
  property p_hot; !(pin_analog.converter_out_pin1 && pin_analog.converter_out_pin2); endproperty
  a_hot: assert property (p_hot) else $error("two pins");
  // read path is registered, so the forced zero lags the override by a cycle
  property p_rd; pin_analog.converter_out_pin1 [*2] |-> !pin1_read; endproperty
  a_rd: assert property (p_rd) else $error("pin read");
  property p_pos; wc |=> ladder.pos_fixed_ref == ($past(pwdata[3:2]) == 2'h2); endproperty
  a_pos: assert property (p_pos) else $error("pos wrong");
  property p_neg; wc |=> ladder.neg_ext_ref == $past(pwdata[0]) && !ladder.neg_ground == $past(pwdata[0]); endproperty
  a_neg: assert property (p_neg) else $error("neg wrong");
  property p_err; psel && penable && paddr != 14'h2438 && paddr != 14'h243C |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
endmodule // dacc_properties

bind dacc_top dacc_properties dacc_properties_i (.clk, .reset_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pslverr, .ladder, .pin_analog, .pin1_read);

// File: verif/dacc_top_test.sv
// self-checking bench for the converter control block
module dacc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dacc_pkg::*;
  logic         clk, reset_n, psel, penable, pwrite, sleep_mode, e;
  logic         pready, pslverr, pin1_read, pin2_read, pad_in_pin1, pad_in_pin2;
  logic [13:0]  paddr;
  logic [31:0]  pwdata, prdata, r;
  logic [3:0]   pstrb;
  dacc_ladder_t ladder;
  dacc_pins_t   pin_analog, pin_digital_off, pin_pullup_off, pin_ccd_off;
  int           error_cnt, samples_checked, cycles;
  dacc_top dacc_top_i (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .sleep_mode, .ladder, .pin_analog, .pin_digital_off,
    .pin_pullup_off, .pin_ccd_off, .pad_in_pin1, .pad_in_pin2, .pin1_read, .pin2_read);
  ////////////////////////////////////////////////////////////////////////////
  // 8 ns clock and a hang limit far above the under one hundred cycles needed
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // one apb transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk({ladder.enable, pin_analog, ladder.level_code}, 32'h0);
    apb(1'b0, 14'h2438, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 14'h243C, 32'h0);
    chk({e, r[30:0]}, 32'h0);
  endtask
  task automatic t_ctrl();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 14'h2438, 32'hC3 | (i << 2));
      sleep_mode <= i[0];
      apb(1'b0, 14'h2438, 32'h0);
      chk(r, 32'h81 | (i << 2));
      chk({ladder.enable, ladder.neg_ext_ref}, 32'h3);
      chk({ladder.pos_supply, ladder.pos_ext_ref, ladder.pos_fixed_ref},
          {i == 0, i == 1, i == 2});
    end
    apb(1'b1, 14'h2438, 32'h0);
    chk({ladder.enable, ladder.neg_ground}, 32'h1);
  endtask
  task automatic t_pins();
    pad_in_pin1 <= 1'b1;
    pad_in_pin2 <= 1'b1;
    apb(1'b1, 14'h2438, 32'h20);
    repeat (4) @(posedge clk);
    chk({pin_analog, pin_digital_off, pin_pullup_off, pin_ccd_off}, 32'hAA);
    chk({pin1_read, pin2_read}, 32'h1);
    apb(1'b1, 14'h2438, 32'h30);
    apb(1'b0, 14'h2438, 32'h0);
    chk(r, 32'h20);
    apb(1'b1, 14'h2438, 32'h10);
    chk(pin_analog, 32'h1);
  endtask
  task automatic t_level();
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, 14'h243C, k ? 32'hAA : 32'hFF);
      apb(1'b0, 14'h243C, 32'h0);
      chk({r, ladder.level_code}, k ? 32'h14A : 32'h3FF);
    end
    // a write with the low strobe off must leave the code alone
    pstrb <= 4'h0;
    apb(1'b1, 14'h243C, 32'h01);
    pstrb <= 4'hF;
    chk(ladder.level_code, 32'h0A);
    apb(1'b1, 14'h2440, 32'hFF);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    chk(ladder.level_code, 32'h0A);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, sleep_mode, pad_in_pin1, pad_in_pin2} = '0;
    pstrb = 4'hF;
    reset_n = 1'b0;
    t_reset();
    t_ctrl();
    t_pins();
    t_level();
    t_reset();
    close_out();
  end
endmodule // dacc_top_test
